// >>> pkg/sideband_consts.vh
`ifndef SIDEBAND_CONSTS_VH
`define SIDEBAND_CONSTS_VH

////////////////////////////////////////////////////////////////////////////////
// Two-wire bus address and memory map.

`define BUS_DEV_ADDR 7'h50
`define MAP_STATUS 8'h00
`define MAP_LOS 8'h01
`define MAP_TXDIS 8'h02
`define MAP_LOS_ASSERT 8'h03
`define MAP_LOS_CLEAR 8'h04
`define MAP_TXSTATE 8'h05
`define MAP_MON_BASE 8'h10

////////////////////////////////////////////////////////////////////////////////
// Field positions in the status byte.

`define STATUS_DNR_BIT 0
`define STATUS_LOS_BIT 1
`define STATUS_DONE_BIT 2

////////////////////////////////////////////////////////////////////////////////
// Reset values.

`define TXDIS_RST 8'h00
`define LOS_ASSERT_RST 8'h10
`define LOS_CLEAR_RST 8'h20
`define SYNC_RST 6'h3F

////////////////////////////////////////////////////////////////////////////////
// Timing.

`define CLK_PERIOD_NS 10
`define RESET_MIN_NS 10000
`define INIT_DONE_NS 100000

`endif

// >>> rtl/sync_2ff.v
`timescale 1ns/1ps
`default_nettype none

module sync_2ff #(
    parameter WIDTH = 6,
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b1}}
)(
    input wire clk_sys,
    input wire arst_n,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_q
);

// The first stage feeds only the second stage.
reg [WIDTH-1:0] meta_q;

always @(posedge clk_sys or negedge arst_n)
begin
    if (!arst_n)
    begin
        meta_q <= RST_VAL;
        sync_q <= RST_VAL;
    end
    else
    begin
        meta_q <= async_in;
        sync_q <= meta_q;
    end
end

endmodule
`default_nettype wire

// >>> rtl/twowire_slave.v
`timescale 1ns/1ps
`default_nettype none
`include "sideband_consts.vh"

module twowire_slave #(
    parameter [6:0] DEV_ADDR = `BUS_DEV_ADDR
)(
    input wire clk_sys,
    input wire arst_n,
    input wire enable,
    input wire scl_s,
    input wire sda_s,
    input wire [7:0] rdata,
    output reg sda_oe_q,
    output reg wr_stb_q,
    output reg rd_stb_q,
    output reg [7:0] addr_q,
    output reg [7:0] wdata_q
);

localparam [6:0] S_IDLE = 7'h01;
localparam [6:0] S_ADDR = 7'h02;
localparam [6:0] S_AACK = 7'h04;
localparam [6:0] S_WR = 7'h08;
localparam [6:0] S_WACK = 7'h10;
localparam [6:0] S_RD = 7'h20;
localparam [6:0] S_RACK = 7'h40;

reg [6:0] st_q;
reg [2:0] bit_q;
reg [7:0] sh_q;
reg scl_p_q;
reg sda_p_q;
reg rw_q;
reg ptr_q;
reg ackd_q;

wire scl_rise = scl_s & ~scl_p_q;
wire scl_fall = ~scl_s & scl_p_q;
wire start = scl_s & scl_p_q & sda_p_q & ~sda_s;
wire stop = scl_s & scl_p_q & ~sda_p_q & sda_s;
wire [7:0] byte_in = {sh_q[6:0], sda_s};

////////////////////////////////////////////////////////////////////////////////
// Bit engine. Data changes only on SCL falls, so our own drive never looks
// like a start or stop condition.

always @(posedge clk_sys or negedge arst_n)
begin
    if (!arst_n)
    begin
        st_q <= S_IDLE;
        bit_q <= 3'h7;
        sh_q <= 8'h00;
        scl_p_q <= 1'b1;
        sda_p_q <= 1'b1;
        rw_q <= 1'b0;
        ptr_q <= 1'b1;
        ackd_q <= 1'b0;
        sda_oe_q <= 1'b0;
        wr_stb_q <= 1'b0;
        rd_stb_q <= 1'b0;
        addr_q <= 8'h00;
        wdata_q <= 8'h00;
    end
    else
    begin
        scl_p_q <= scl_s;
        sda_p_q <= sda_s;
        wr_stb_q <= 1'b0;
        rd_stb_q <= 1'b0;
        if (wr_stb_q)
            addr_q <= addr_q + 8'h01;
        if (!enable || stop)
        begin
            st_q <= S_IDLE;
            sda_oe_q <= 1'b0;
        end
        else if (start)
        begin
            st_q <= S_ADDR;
            bit_q <= 3'h7;
            sda_oe_q <= 1'b0;
        end
        else
        begin
            case (st_q)
                S_ADDR:
                    if (scl_rise)
                    begin
                        sh_q <= byte_in;
                        bit_q <= bit_q - 3'h1;
                        if (bit_q == 3'h0)
                        begin
                            rw_q <= sda_s;
                            st_q <= (sh_q[6:0] == DEV_ADDR) ? S_AACK : S_IDLE;
                        end
                    end
                S_AACK:
                    if (scl_fall)
                    begin
                        if (!sda_oe_q)
                            sda_oe_q <= 1'b1;
                        else if (rw_q)
                        begin
                            sh_q <= rdata;
                            sda_oe_q <= ~rdata[7];
                            rd_stb_q <= 1'b1;
                            bit_q <= 3'h7;
                            st_q <= S_RD;
                        end
                        else
                        begin
                            sda_oe_q <= 1'b0;
                            ptr_q <= 1'b1;
                            bit_q <= 3'h7;
                            st_q <= S_WR;
                        end
                    end
                S_WR:
                    if (scl_rise)
                    begin
                        sh_q <= byte_in;
                        bit_q <= bit_q - 3'h1;
                        if (bit_q == 3'h0)
                        begin
                            st_q <= S_WACK;
                            ptr_q <= 1'b0;
                            if (ptr_q)
                                addr_q <= byte_in;
                            else
                            begin
                                wr_stb_q <= 1'b1;
                                wdata_q <= byte_in;
                            end
                        end
                    end
                S_WACK:
                    if (scl_fall)
                    begin
                        if (!sda_oe_q)
                            sda_oe_q <= 1'b1;
                        else
                        begin
                            sda_oe_q <= 1'b0;
                            bit_q <= 3'h7;
                            st_q <= S_WR;
                        end
                    end
                S_RD:
                    if (scl_fall)
                    begin
                        if (bit_q == 3'h0)
                        begin
                            sda_oe_q <= 1'b0;
                            ackd_q <= 1'b0;
                            st_q <= S_RACK;
                        end
                        else
                        begin
                            sda_oe_q <= ~sh_q[6];
                            sh_q <= {sh_q[6:0], 1'b0};
                            bit_q <= bit_q - 3'h1;
                        end
                    end
                S_RACK:
                    if (scl_rise)
                    begin
                        if (sda_s)
                            st_q <= S_IDLE;
                        else
                        begin
                            addr_q <= addr_q + 8'h01;
                            ackd_q <= 1'b1;
                        end
                    end
                    else if (scl_fall && ackd_q)
                    begin
                        sh_q <= rdata;
                        sda_oe_q <= ~rdata[7];
                        rd_stb_q <= 1'b1;
                        bit_q <= 3'h7;
                        ackd_q <= 1'b0;
                        st_q <= S_RD;
                    end
                default:
                    st_q <= S_IDLE;
            endcase
        end
    end
end

endmodule
`default_nettype wire

// >>> rtl/optical_module_sideband_control.v
`timescale 1ns/1ps
`default_nettype none
`include "sideband_consts.vh"

// Summary of operation
// - Bus answered only while select held low.
// - Long hard reset restores every default setting.
// - Completion asserts alert, clears not-ready flag.
// - Power-up posts completion without hard reset.
// - Low-power pin high turns lasers off.
// - Pin or bus setting disables transmitter.
// - Presence pulled low while module inserted.
// - Loss alarm when any lane below threshold.
// - Alert driven low while signal loss asserted.
// - Other alarms stay off the alert pin.
// - Per-lane received power readable over bus.
// - Eight low-speed sideband pins form interface.
module optical_module_sideband_control #(
    parameter LANES = 4,
    parameter MON_W = 16,
    parameter CNT_W = 24,
    parameter RESET_MIN_NS = `RESET_MIN_NS,
    parameter INIT_DONE_NS = `INIT_DONE_NS
)(
    input wire clk_sys,
    input wire arst_n,
    input wire module_select_n,
    input wire hard_reset_n,
    input wire low_power_tx_off,
    input wire transmit_disable,
    input wire scl,
    input wire sda_i,
    output reg sda_o,
    output wire sda_oe,
    output reg presence_n_o,
    output reg presence_n_oe,
    output reg alert_n_o,
    output reg alert_n_oe,
    input wire [LANES*MON_W-1:0] rx_power,
    output reg [LANES-1:0] laser_en,
    output reg receive_signal_loss,
    output reg data_not_ready
);

localparam [CNT_W-1:0] RESET_MIN_CYC =
    (RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
localparam [CNT_W-1:0] INIT_DONE_CYC = INIT_DONE_NS / `CLK_PERIOD_NS;
localparam [7:0] TXDIS_RST_B = `TXDIS_RST;
localparam [LANES-1:0] TXDIS_RST_L = TXDIS_RST_B[LANES-1:0];

localparam [2:0] ST_INIT = 3'h1;
localparam [2:0] ST_RUN = 3'h2;
localparam [2:0] ST_HELD = 3'h4;

////////////////////////////////////////////////////////////////////////////////
// Pin synchronizers. Idle values keep the bus released and the lasers off.

wire [5:0] pins_s;
wire sel_n_s = pins_s[0];
wire hrst_n_s = pins_s[1];
wire lp_s = pins_s[2];
wire txdis_s = pins_s[3];
wire scl_s = pins_s[4];
wire sda_s = pins_s[5];

sync_2ff #(
    .WIDTH(6),
    .RST_VAL(`SYNC_RST)
) u_sync (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .async_in({sda_i, scl, transmit_disable, low_power_tx_off,
               hard_reset_n, module_select_n}),
    .sync_q(pins_s)
);

////////////////////////////////////////////////////////////////////////////////
// Two-wire slave.

reg [2:0] st_q;
reg [7:0] rdata;
wire wr_stb;
wire rd_stb;
wire [7:0] bus_addr;
wire [7:0] bus_wdata;
wire held = st_q[2];

twowire_slave #(
    .DEV_ADDR(`BUS_DEV_ADDR)
) u_slave (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .enable(~sel_n_s & ~held),
    .scl_s(scl_s),
    .sda_s(sda_s),
    .rdata(rdata),
    .sda_oe_q(sda_oe),
    .wr_stb_q(wr_stb),
    .rd_stb_q(rd_stb),
    .addr_q(bus_addr),
    .wdata_q(bus_wdata)
);

////////////////////////////////////////////////////////////////////////////////
// Reset sequencing. A low pulse shorter than the minimum is ignored, so
// glitches on a long cable never wipe the settings.

reg [CNT_W-1:0] low_cnt_q;
reg [CNT_W-1:0] init_cnt_q;
reg done_alert_q;

// The lasers follow the hold decision itself rather than the registered state,
// so they go dark on the same edge at which the not-ready flag rises.
wire hold_req = !hrst_n_s && (low_cnt_q == RESET_MIN_CYC);

wire status_read = rd_stb && (bus_addr == `MAP_STATUS);

always @(posedge clk_sys or negedge arst_n)
begin
    if (!arst_n)
    begin
        st_q <= ST_INIT;
        low_cnt_q <= {CNT_W{1'b0}};
        init_cnt_q <= {CNT_W{1'b0}};
        data_not_ready <= 1'b1;
        done_alert_q <= 1'b0;
    end
    else
    begin
        if (hrst_n_s)
            low_cnt_q <= {CNT_W{1'b0}};
        else if (low_cnt_q != RESET_MIN_CYC)
            low_cnt_q <= low_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
        case (st_q)
            ST_INIT:
            begin
                if (!hrst_n_s && low_cnt_q == RESET_MIN_CYC)
                    st_q <= ST_HELD;
                else if (init_cnt_q == INIT_DONE_CYC)
                begin
                    st_q <= ST_RUN;
                    data_not_ready <= 1'b0;
                    done_alert_q <= 1'b1;
                end
                else
                    init_cnt_q <= init_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
            end
            ST_RUN:
            begin
                if (!hrst_n_s && low_cnt_q == RESET_MIN_CYC)
                begin
                    st_q <= ST_HELD;
                    data_not_ready <= 1'b1;
                    done_alert_q <= 1'b0;
                end
                else if (status_read)
                    done_alert_q <= 1'b0;
            end
            ST_HELD:
            begin
                data_not_ready <= 1'b1;
                done_alert_q <= 1'b0;
                init_cnt_q <= {CNT_W{1'b0}};
                if (hrst_n_s)
                    st_q <= ST_INIT;
            end
            default:
                st_q <= ST_INIT;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// Writable settings. All of them return to defaults while reset is held.

reg [LANES-1:0] txdis_reg_q;
reg [7:0] los_assert_q;
reg [7:0] los_clear_q;

always @(posedge clk_sys or negedge arst_n)
begin
    if (!arst_n)
    begin
        txdis_reg_q <= TXDIS_RST_L;
        los_assert_q <= `LOS_ASSERT_RST;
        los_clear_q <= `LOS_CLEAR_RST;
    end
    else if (held)
    begin
        txdis_reg_q <= TXDIS_RST_L;
        los_assert_q <= `LOS_ASSERT_RST;
        los_clear_q <= `LOS_CLEAR_RST;
    end
    else if (wr_stb)
    begin
        if (bus_addr == `MAP_TXDIS)
            txdis_reg_q <= bus_wdata[LANES-1:0];
        else if (bus_addr == `MAP_LOS_ASSERT)
            los_assert_q <= bus_wdata;
        else if (bus_addr == `MAP_LOS_CLEAR)
            los_clear_q <= bus_wdata;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Received power monitor and per-lane loss detection with hysteresis. Only
// the upper byte of each reading is compared, which keeps the thresholds
// one byte wide at the cost of fine resolution.

reg [LANES*MON_W-1:0] diagnostic_monitor_q;
reg [LANES-1:0] los_q;
wire [LANES-1:0] los_d;

genvar i;
generate
    for (i = 0; i < LANES; i = i + 1)
    begin : g_lane
        wire [7:0] pwr_hi = diagnostic_monitor_q[i*MON_W+MON_W-1 -: 8];
        assign los_d[i] = (pwr_hi < los_assert_q) ? 1'b1 :
                          (pwr_hi >= los_clear_q) ? 1'b0 : los_q[i];
    end
endgenerate

always @(posedge clk_sys or negedge arst_n)
begin
    if (!arst_n)
    begin
        diagnostic_monitor_q <= {(LANES*MON_W){1'b0}};
        los_q <= {LANES{1'b0}};
        receive_signal_loss <= 1'b0;
    end
    else
    begin
        diagnostic_monitor_q <= rx_power;
        los_q <= los_d;
        receive_signal_loss <= |los_q;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Pin outputs. Alert carries only signal loss and reset completion; other
// alarms are left to the memory map.

always @(posedge clk_sys or negedge arst_n)
begin
    if (!arst_n)
    begin
        sda_o <= 1'b0;
        presence_n_o <= 1'b0;
        presence_n_oe <= 1'b1;
        alert_n_o <= 1'b0;
        alert_n_oe <= 1'b0;
        laser_en <= {LANES{1'b0}};
    end
    else
    begin
        sda_o <= 1'b0;
        presence_n_o <= 1'b0;
        presence_n_oe <= 1'b1;
        alert_n_o <= 1'b0;
        alert_n_oe <= receive_signal_loss | done_alert_q;
        laser_en <= {LANES{st_q[1] & ~hold_req & ~lp_s & ~txdis_s}}
                    & ~txdis_reg_q;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Read multiplexer. Unmapped addresses read as zero.

reg [7:0] mon_off;
reg [MON_W-1:0] mon_word;

always @*
begin
    mon_off = bus_addr - `MAP_MON_BASE;
    mon_word = diagnostic_monitor_q[mon_off[7:1]*MON_W +: MON_W];
    rdata = 8'h00;
    if (bus_addr == `MAP_STATUS)
    begin
        rdata[`STATUS_DNR_BIT] = data_not_ready;
        rdata[`STATUS_LOS_BIT] = receive_signal_loss;
        rdata[`STATUS_DONE_BIT] = done_alert_q;
    end
    else if (bus_addr == `MAP_LOS)
        rdata[LANES-1:0] = los_q;
    else if (bus_addr == `MAP_TXDIS)
        rdata[LANES-1:0] = txdis_reg_q;
    else if (bus_addr == `MAP_LOS_ASSERT)
        rdata = los_assert_q;
    else if (bus_addr == `MAP_LOS_CLEAR)
        rdata = los_clear_q;
    else if (bus_addr == `MAP_TXSTATE)
        rdata[LANES-1:0] = laser_en;
    else if (bus_addr >= `MAP_MON_BASE && mon_off[7:1] < LANES)
        rdata = mon_off[0] ? mon_word[7:0] : mon_word[MON_W-1 -: 8];
end

endmodule
`default_nettype wire

// >>> bench/sideband_checker_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "sideband_consts.vh"

module sideband_checker #(
    parameter LANES = 4,
    parameter MON_W = 16
)(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic module_select_n,
    input wire logic low_power_tx_off,
    input wire logic transmit_disable,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic presence_n_o,
    input wire logic presence_n_oe,
    input wire logic alert_n_o,
    input wire logic alert_n_oe,
    input wire logic [LANES*MON_W-1:0] rx_power,
    input wire logic [LANES-1:0] laser_en,
    input wire logic receive_signal_loss,
    input wire logic data_not_ready
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    ////////////////////////////////////////////////////////////////////////////
    // The loss checks assume the thresholds keep their reset values.
    logic any_low;
    logic all_high;
    always_comb
    begin
        any_low = 1'b0;
        all_high = 1'b1;
        for (int i = 0; i < LANES; i++)
        begin
            if (rx_power[i*MON_W+MON_W-8 +: 8] < `LOS_ASSERT_RST)
                any_low = 1'b1;
            if (rx_power[i*MON_W+MON_W-8 +: 8] < `LOS_CLEAR_RST)
                all_high = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    property p_sel_quiet;
        module_select_n [*5] |-> !sda_oe;
    endproperty
    a_sel_quiet: assert property (p_sel_quiet) else $error("bus driven while deselected");
    property p_lp_off;
        low_power_tx_off [*4] |-> laser_en == 4'h0;
    endproperty
    a_lp_off: assert property (p_lp_off) else $error("laser on in low power");
    property p_txd_off;
        transmit_disable [*4] |-> laser_en == 4'h0;
    endproperty
    a_txd_off: assert property (p_txd_off) else $error("laser on while disabled");
    property p_init_dark;
        (|laser_en) |-> !data_not_ready;
    endproperty
    a_init_dark: assert property (p_init_dark) else $error("laser on before ready");
    property p_presence;
        presence_n_oe && !presence_n_o;
    endproperty
    a_presence: assert property (p_presence) else $error("presence not pulled low");
    property p_open_drain;
        !sda_o && !alert_n_o;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("pin driven high");
    property p_los_set;
        (any_low && !data_not_ready) [*5] |-> receive_signal_loss;
    endproperty
    a_los_set: assert property (p_los_set) else $error("loss not raised");
    property p_los_clr;
        (all_high && !data_not_ready) [*5] |-> !receive_signal_loss;
    endproperty
    a_los_clr: assert property (p_los_clr) else $error("loss not cleared");
    property p_los_alert;
        receive_signal_loss |=> alert_n_oe;
    endproperty
    a_los_alert: assert property (p_los_alert) else $error("alert missing on loss");
    property p_done_alert;
        $fell(data_not_ready) |-> ##[0:1] alert_n_oe;
    endproperty
    a_done_alert: assert property (p_done_alert) else $error("no completion alert");
endmodule

bind optical_module_sideband_control sideband_checker #(.LANES(LANES), .MON_W(MON_W)) chk (
    .clk_sys(clk_sys), .arst_n(arst_n), .module_select_n(module_select_n),
    .low_power_tx_off(low_power_tx_off), .transmit_disable(transmit_disable),
    .sda_o(sda_o), .sda_oe(sda_oe), .presence_n_o(presence_n_o),
    .presence_n_oe(presence_n_oe), .alert_n_o(alert_n_o), .alert_n_oe(alert_n_oe),
    .rx_power(rx_power), .laser_en(laser_en), .receive_signal_loss(receive_signal_loss),
    .data_not_ready(data_not_ready));
`default_nettype wire

// >>> bench/host_master.sv
`timescale 1ns/1ps
`default_nettype none
`include "sideband_consts.vh"

module host_master (
    input wire logic dev_oe,
    output logic scl,
    output wire logic sda
);
    logic pull;
    // Pulled-up wire: it reads high whenever neither side pulls it down.
    assign sda = ~(pull | dev_oe);
    initial
    begin
        scl = 1'b1;
        pull = 1'b0;
    end
    // Long start and stop phases leave room for the slave's late ack release.
    task automatic start();
        pull = 1'b0;
        #62.5 scl = 1'b1;
        #62.5 pull = 1'b1;
        #62.5 scl = 1'b0;
    endtask
    task automatic stop();
        #62.5 pull = 1'b1;
        #62.5 scl = 1'b1;
        #62.5 pull = 1'b0;
        #62.5;
    endtask
    task automatic clock_bit(input logic low, output logic seen);
        #31.25 pull = low;
        #31.25 scl = 1'b1;
        #31.25 seen = sda;
        #31.25 scl = 1'b0;
    endtask
    task automatic xfer(input logic [7:0] wb, input logic rel, output logic [7:0] rb,
                        output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            clock_bit(~wb[i], s);
            rb[i] = s;
        end
        clock_bit(~rel, s);
        ack = ~s;
    endtask
    task automatic wr_reg(input logic [7:0] ptr, input logic [7:0] d, output logic ok);
        logic [7:0] j;
        logic a0, a1, a2;
        // The odd offset keeps every bus edge off the system clock edge.
        #0.5;
        start();
        xfer({`BUS_DEV_ADDR, 1'b0}, 1'b1, j, a0);
        xfer(ptr, 1'b1, j, a1);
        xfer(d, 1'b1, j, a2);
        stop();
        ok = a0 & a1 & a2;
    endtask
    task automatic rd_reg(input logic [7:0] ptr, output logic [7:0] d, output logic ok);
        logic [7:0] j;
        logic a0, a1, a2, a3;
        #0.5;
        start();
        xfer({`BUS_DEV_ADDR, 1'b0}, 1'b1, j, a0);
        xfer(ptr, 1'b1, j, a1);
        start();
        xfer({`BUS_DEV_ADDR, 1'b1}, 1'b1, j, a2);
        xfer(8'hFF, 1'b1, d, a3);
        stop();
        ok = a0 & a1 & a2;
    endtask
endmodule
`default_nettype wire

// >>> bench/optical_module_sideband_control_test.sv
`timescale 1ns/1ps
`default_nettype none

module optical_module_sideband_control_test;
    logic clk_sys, arst_n, module_select_n, hard_reset_n, low_power_tx_off, transmit_disable;
    logic [63:0] rx_power;
    wire logic scl, sda, sda_o, sda_oe, presence_n_o, presence_n_oe, alert_n_o, alert_n_oe;
    wire logic receive_signal_loss, data_not_ready;
    wire logic [3:0] laser_en;
    wire logic alert_pin = alert_n_oe ? alert_n_o : 1'b1;
    wire logic presence_pin = presence_n_oe ? presence_n_o : 1'b1;
    int failures = 0;
    int checked = 0;
    logic [7:0] rd;
    logic ok;

    optical_module_sideband_control #(.RESET_MIN_NS(1000), .INIT_DONE_NS(2000)) dut (
        .clk_sys(clk_sys), .arst_n(arst_n), .module_select_n(module_select_n),
        .hard_reset_n(hard_reset_n), .low_power_tx_off(low_power_tx_off),
        .transmit_disable(transmit_disable), .scl(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .presence_n_o(presence_n_o), .presence_n_oe(presence_n_oe),
        .alert_n_o(alert_n_o), .alert_n_oe(alert_n_oe), .rx_power(rx_power),
        .laser_en(laser_en), .receive_signal_loss(receive_signal_loss),
        .data_not_ready(data_not_ready));
    host_master host (.dev_oe(sda_oe), .scl(scl), .sda(sda));

    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // Status is only trusted once the module reports ready.
    task automatic wait_ready();
        int k;
        k = 0;
        while (data_not_ready !== 1'b0 && k < 400)
        begin
            cyc(1);
            k++;
        end
        if (k == 400)
        begin
            failures++;
            $display("unexpected ready wait: expected 0 seen %b", data_not_ready);
            wrap_up();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_powerup();
        wait_ready();
        cyc(2);
        check("completion alert", 8'h00, alert_pin);
        check("presence", 8'h00, presence_pin);
        host.rd_reg(8'h00, rd, ok);
        check("status", 8'h04, rd);
        cyc(3);
        check("alert after status read", 8'h01, alert_pin);
        $display("test powerup done");
    endtask
    task automatic t_pins();
        check("lasers on", 8'h0F, laser_en);
        low_power_tx_off <= 1'b1;
        cyc(4);
        check("low power lasers", 8'h00, laser_en);
        low_power_tx_off <= 1'b0;
        transmit_disable <= 1'b1;
        cyc(4);
        check("disable pin lasers", 8'h00, laser_en);
        transmit_disable <= 1'b0;
        cyc(4);
        check("lasers back", 8'h0F, laser_en);
        $display("test pins done");
    endtask
    task automatic t_bus();
        host.wr_reg(8'h02, 8'h05, ok);
        check("write ack", 8'h01, ok);
        cyc(3);
        check("bus disable lasers", 8'h0A, laser_en);
        host.rd_reg(8'h05, rd, ok);
        check("laser state byte", 8'h0A, rd);
        host.rd_reg(8'h30, rd, ok);
        check("unmapped read", 8'h00, rd);
        $display("test bus done");
    endtask
    task automatic t_select();
        module_select_n <= 1'b1;
        cyc(4);
        host.wr_reg(8'h02, 8'h0F, ok);
        check("deselected ack", 8'h00, ok);
        module_select_n <= 1'b0;
        cyc(4);
        check("lasers kept", 8'h0A, laser_en);
        $display("test select done");
    endtask
    task automatic t_monitor();
        rx_power[31:16] <= 16'h3A5C;
        cyc(4);
        host.rd_reg(8'h12, rd, ok);
        check("monitor msb", 8'h3A, rd);
        host.rd_reg(8'h13, rd, ok);
        check("monitor lsb", 8'h5C, rd);
        $display("test monitor done");
    endtask
    task automatic t_loss();
        rx_power[47:32] <= 16'h0800;
        cyc(5);
        check("loss flag", 8'h01, receive_signal_loss);
        check("alert on loss", 8'h00, alert_pin);
        host.rd_reg(8'h01, rd, ok);
        check("lane loss flags", 8'h04, rd);
        rx_power[47:32] <= 16'h3000;
        cyc(6);
        check("loss cleared", 8'h00, receive_signal_loss);
        check("alert released", 8'h01, alert_pin);
        $display("test loss done");
    endtask
    task automatic t_hard_reset();
        hard_reset_n <= 1'b0;
        cyc(50);
        hard_reset_n <= 1'b1;
        cyc(5);
        check("short pulse ready", 8'h00, data_not_ready);
        check("short pulse lasers", 8'h0A, laser_en);
        hard_reset_n <= 1'b0;
        cyc(130);
        check("held reset busy", 8'h01, data_not_ready);
        check("held reset lasers", 8'h00, laser_en);
        hard_reset_n <= 1'b1;
        wait_ready();
        cyc(2);
        check("defaults lasers", 8'h0F, laser_en);
        check("completion again", 8'h00, alert_pin);
        host.rd_reg(8'h02, rd, ok);
        check("disable default", 8'h00, rd);
        $display("test hard reset done");
    endtask

    initial
    begin
        arst_n = 1'b0;
        module_select_n = 1'b0;
        hard_reset_n = 1'b1;
        low_power_tx_off = 1'b0;
        transmit_disable = 1'b0;
        rx_power = {4{16'h3000}};
        cyc(2);
        arst_n <= 1'b1;
        t_powerup();
        t_pins();
        t_bus();
        t_select();
        t_monitor();
        t_loss();
        t_hard_reset();
        wrap_up();
    end
endmodule
`default_nettype wire
